// ---- logic/rsw_regs.svh ----
// Register map, field positions, reset values and timing counts of the
// reset controller and watchdog. Assumes APB byte addresses of 4 * index.
`ifndef RSW_REGS_SVH
`define RSW_REGS_SVH

// ---------------------------------------------------------------------
// Register indices
// ---------------------------------------------------------------------
`define RSW_IDX_OPTIONS  6'h39
`define RSW_IDX_SERVICE  6'h3a
`define RSW_IDX_STATUS   6'h3b
`define RSW_IDX_TEST     6'h3e
`define RSW_IDX_CONFIG   6'h3f

// ---------------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------------
`define RSW_OPT_RESET    8'h10
`define RSW_OPT_CME      3
`define RSW_OPT_CLOCK_MONITOR_FORCE     2
`define RSW_CFG_RESET    8'h00
`define RSW_CFG_WDDIS    2
`define RSW_TST_INHIBIT  7
`define RSW_SVC_ARM      8'h55
`define RSW_SVC_CLEAR    8'haa
`define RSW_VEC_NORMAL   8'hff
`define RSW_VEC_SPECIAL  8'hbf
`define RSW_VEC_EXT      8'hfe
`define RSW_VEC_CMON     8'hfc
`define RSW_VEC_WDOG     8'hfa

// ---------------------------------------------------------------------
// Cycle counts
// ---------------------------------------------------------------------
`define RSW_POR_CYC      12'd4064
`define RSW_DRIVE_CYC    12'd4
`define RSW_SETTLE_CYC   12'd2
`define RSW_SYNC_LAT     12'd2
`define RSW_FETCH_CYC    12'd3
`define RSW_RATE_WIN     7'd64

`endif

// ---- logic/rsw_pkg.sv ----
// Types shared by the reset controller modules.
// Assumes nothing beyond a SystemVerilog tool.
`default_nettype none
package rsw_pkg;
  typedef enum logic [2:0] {
    ST_POR, ST_HOLD, ST_DRIVE, ST_SETTLE, ST_FETCH, ST_RUN
  } rsw_state_e;
  typedef enum logic [1:0] {
    CAUSE_EXT, CAUSE_CMON, CAUSE_WDOG
  } rsw_cause_e;
endpackage
`default_nettype wire

// ---- logic/rsw_ctl_if.sv ----
// Signals between the reset controller and its two timers.
// Assumes all three sit on the same clock.
`default_nettype none
interface rsw_ctl_if;
  logic       wd_run;
  logic [1:0] rate;
  logic       svc_wr;
  logic [7:0] svc_data;
  logic       wd_fire;
  logic       cm_en;
  logic       e_sync;
  logic       cm_fail;
  modport ctl  (output wd_run, rate, svc_wr, svc_data, cm_en, e_sync,
                input  wd_fire, cm_fail);
  modport wdog (input  wd_run, rate, svc_wr, svc_data,
                output wd_fire);
  modport cmon (input  cm_en, e_sync,
                output cm_fail);
endinterface
`default_nettype wire

// ---- logic/rsw_wdog.sv ----
// Free-running watchdog counter with arm-then-clear service.
// Assumes wd_run falls whenever the system is in reset.
`include "rsw_regs.svh"
`default_nettype none
module rsw_wdog #(
  parameter int BASE_LOG2 = 15
) (
  // Clock and reset
  input wire logic  clk,
  input wire logic  reset_n,
  // Control
  rsw_ctl_if.wdog   ctl
);
  localparam int W = BASE_LOG2 + 7;

  // Timeout in cycles for a rate code.
  function automatic logic [W-1:0] limit(input logic [1:0] r);
    limit = W'(1) << (BASE_LOG2 + 2 * int'(r));
  endfunction

  logic [W-1:0] cnt_q;
  logic         armed_q;
  logic         fire_q;
  wire          arm_wr = ctl.svc_wr && ctl.svc_data == `RSW_SVC_ARM;
  wire          clr_wr = ctl.svc_wr && ctl.svc_data == `RSW_SVC_CLEAR;
  wire          expire = cnt_q == limit(ctl.rate) - W'(1);

  assign ctl.wd_fire = fire_q;

  // Counter restarts on service or expiry; any other write leaves it.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q   <= '0;
      armed_q <= 1'b0;
      fire_q  <= 1'b0;
    end
    else
    begin
      fire_q <= ctl.wd_run && expire;
      if (!ctl.wd_run || expire || (clr_wr && armed_q))
        cnt_q <= '0;
      else
        cnt_q <= cnt_q + W'(1);
      if (!ctl.wd_run || (clr_wr && armed_q))
        armed_q <= 1'b0;
      else if (arm_wr)
        armed_q <= 1'b1;
    end
  end
endmodule // rsw_wdog
`default_nettype wire

// ---- logic/rsw_cmon.sv ----
// Clock monitor: counts free-running oscillator cycles between edges
// of the synchronised E clock. Assumes clk is the independent oscillator.
`default_nettype none
module rsw_cmon #(
  parameter int TMO = 2000
) (
  // Clock and reset
  input wire logic  clk,
  input wire logic  reset_n,
  // Control
  rsw_ctl_if.cmon   ctl
);
  logic [15:0] cnt_q;
  logic        last_q;
  logic        fail_q;
  wire         edge_seen = ctl.e_sync != last_q;
  wire         late = cnt_q == 16'(TMO);

  assign ctl.cm_fail = fail_q;

  // Any edge restarts the count; disabled monitor never fails.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q  <= '0;
      last_q <= 1'b0;
      fail_q <= 1'b0;
    end
    else
    begin
      last_q <= ctl.e_sync;
      fail_q <= ctl.cm_en && late && !edge_seen;
      if (!ctl.cm_en || edge_seen || late)
        cnt_q <= '0;
      else
        cnt_q <= cnt_q + 16'd1;
    end
  end
endmodule // rsw_cmon
`default_nettype wire

// ---- logic/rsw_top.sv ----
// Reset sequencer, restart vector selection, APB registers, watchdog
// and clock monitor. Assumes reset_n is the power-on detector and that
// the reset pin has a pull-up outside.
//
// The implementer's own choice: the APB slave port.
`include "rsw_regs.svh"
`default_nettype none
module rsw_top #(
  parameter int WD_BASE_LOG2 = 15,
  parameter int CM_TMO       = 2000
) (
  // Clock and power-on reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Reset pin, open drain
  input  wire logic        rst_pin_i,
  output var  logic        rst_pin_o,
  output var  logic        rst_pin_oe,
  // Mode and monitored clock pins
  input  wire logic        special_mode_pin,
  input  wire logic        e_clk_pin,
  // Processor core side
  output var  logic        core_rst_n,
  output var  logic        vec_fetch,
  output var  logic [15:0] vec_addr
);

  // -------------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------------
  logic [1:0] pin_sync_q;
  logic [1:0] mode_sync_q;
  logic [1:0] eclk_sync_q;
  wire        pin_s  = pin_sync_q[1];
  wire        mode_s = mode_sync_q[1];

  // Two stages each; only the second stage is read by logic.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_sync_q  <= 2'b00;
      mode_sync_q <= 2'b00;
      eclk_sync_q <= 2'b00;
    end
    else
    begin
      pin_sync_q  <= {pin_sync_q[0], rst_pin_i};
      mode_sync_q <= {mode_sync_q[0], special_mode_pin};
      eclk_sync_q <= {eclk_sync_q[0], e_clk_pin};
    end
  end

  // -------------------------------------------------------------------
  // Timers
  // -------------------------------------------------------------------
  rsw_ctl_if ctl ();

  rsw_wdog #(
    .BASE_LOG2 (WD_BASE_LOG2)
  ) u_wdog (
    .clk     (clk),
    .reset_n (reset_n),
    .ctl     (ctl.wdog)
  );

  rsw_cmon #(
    .TMO     (CM_TMO)
  ) u_cmon (
    .clk     (clk),
    .reset_n (reset_n),
    .ctl     (ctl.cmon)
  );

  // -------------------------------------------------------------------
  // Sequencer state
  // -------------------------------------------------------------------
  rsw_pkg::rsw_state_e state_q;
  rsw_pkg::rsw_state_e state_d;
  rsw_pkg::rsw_cause_e cause_q;
  rsw_pkg::rsw_cause_e cause_d;
  logic [11:0]         cnt_q;
  logic [11:0]         cnt_d;
  logic                pend_cm_q;
  logic                pend_cm_d;

  // Restart vector for a cause and mode.
  function automatic logic [15:0] vector(input rsw_pkg::rsw_cause_e c,
                                         input logic spec);
    logic [7:0] hi;
    logic [7:0] lo;
    hi = spec ? `RSW_VEC_SPECIAL : `RSW_VEC_NORMAL;
    case (c)
      rsw_pkg::CAUSE_CMON: lo = `RSW_VEC_CMON;
      rsw_pkg::CAUSE_WDOG: lo = `RSW_VEC_WDOG;
      default:             lo = `RSW_VEC_EXT;
    endcase
    vector = {hi, lo};
  endfunction

  // -------------------------------------------------------------------
  // Registers and bus decode
  // -------------------------------------------------------------------
  logic [7:0]  opt_q;
  logic [7:0]  cfg_q;
  logic [7:0]  tst_q;
  logic        rate_done_q;
  logic        cfg_done_q;
  logic        clock_monitor_force_q;
  logic [6:0]  win_q;
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;

  wire [5:0] idx      = paddr[7:2];
  wire       in_rst   = state_q != rsw_pkg::ST_RUN;
  wire       acc      = psel && penable && !pready_q;
  wire       done     = psel && penable && pready_q;
  wire       wr       = done && pwrite;
  wire       hit_opt  = idx == `RSW_IDX_OPTIONS;
  wire       hit_svc  = idx == `RSW_IDX_SERVICE;
  wire       hit_sta  = idx == `RSW_IDX_STATUS;
  wire       hit_tst  = idx == `RSW_IDX_TEST;
  wire       hit_cfg  = idx == `RSW_IDX_CONFIG;
  wire       mapped   = hit_opt | hit_svc | hit_sta | hit_tst | hit_cfg;
  wire [7:0] wbyte    = pwdata[7:0];
  wire       rate_ok  = mode_s || (!rate_done_q && win_q < `RSW_RATE_WIN);
  wire       cfg_ok   = mode_s || !cfg_done_q;
  wire [7:0] status   = {5'h00, mode_s, 2'(cause_q)};
  wire [7:0] rd_byte  = hit_opt ? opt_q :
                        hit_sta ? status :
                        hit_tst ? tst_q :
                        hit_cfg ? cfg_q : 8'h00;
  wire       wd_inhib = cfg_q[`RSW_CFG_WDDIS] ||
                        (mode_s && tst_q[`RSW_TST_INHIBIT]);

  // Timer controls.
  assign ctl.wd_run   = !in_rst && !wd_inhib;
  assign ctl.rate     = opt_q[1:0];
  assign ctl.svc_wr   = wr && hit_svc && !in_rst;
  assign ctl.svc_data = wbyte;
  assign ctl.cm_en    = !in_rst && (opt_q[`RSW_OPT_CME] || clock_monitor_force_q);
  assign ctl.e_sync   = eclk_sync_q[1];

  // APB answers one cycle into the access phase.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= acc;
      prdata_q  <= acc && !pwrite ? {24'h000000, rd_byte} : 32'h0000_0000;
      pslverr_q <= acc && !mapped;
    end
  end

  // Options register; all control bits return to reset values while
  // the processor is held in reset.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      opt_q       <= `RSW_OPT_RESET;
      rate_done_q <= 1'b0;
      clock_monitor_force_q      <= 1'b0;
      win_q       <= 7'd0;
    end
    else if (in_rst)
    begin
      opt_q       <= `RSW_OPT_RESET;
      rate_done_q <= 1'b0;
      clock_monitor_force_q      <= 1'b0;
      win_q       <= 7'd0;
    end
    else
    begin
      if (win_q < `RSW_RATE_WIN)
        win_q <= win_q + 7'd1;
      if (wr && hit_opt)
      begin
        opt_q[7:3] <= wbyte[7:3];
        opt_q[2]   <= wbyte[2] || clock_monitor_force_q;
        if (rate_ok)
        begin
          opt_q[1:0]  <= wbyte[1:0];
          rate_done_q <= !mode_s;
        end
        if (wbyte[`RSW_OPT_CLOCK_MONITOR_FORCE])
          clock_monitor_force_q <= 1'b1;
      end
    end
  end

  // Configuration and test registers.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_q      <= `RSW_CFG_RESET;
      cfg_done_q <= 1'b0;
      tst_q      <= 8'h80;
    end
    else if (in_rst)
    begin
      cfg_done_q <= 1'b0;
      tst_q      <= {mode_s, 7'h00};
    end
    else
    begin
      if (wr && hit_cfg && cfg_ok)
      begin
        cfg_q      <= wbyte;
        cfg_done_q <= !mode_s;
      end
      if (wr && hit_tst && mode_s)
        tst_q <= wbyte;
    end
  end

  // -------------------------------------------------------------------
  // Reset sequencer
  // -------------------------------------------------------------------
  // Next state; every source but power-on funnels through the pin drive so the
  // cause is decided by what the pin does after release; power-on sets CAUSE_EXT.
  always_comb
  begin
    state_d   = state_q;
    cause_d   = cause_q;
    cnt_d     = cnt_q + 12'd1;
    pend_cm_d = pend_cm_q;
    case (state_q)
      rsw_pkg::ST_POR:
        if (cnt_q == `RSW_POR_CYC - 12'd1)
        begin
          state_d = rsw_pkg::ST_HOLD;
          cause_d = rsw_pkg::CAUSE_EXT;
          cnt_d   = 12'd0;
        end
      rsw_pkg::ST_HOLD:
      begin
        cnt_d = 12'd0;
        if (pin_s)
          state_d = rsw_pkg::ST_FETCH;
      end
      rsw_pkg::ST_DRIVE:
        if (cnt_q == `RSW_DRIVE_CYC - 12'd1)
        begin
          state_d = rsw_pkg::ST_SETTLE;
          cnt_d   = 12'd0;
        end
      rsw_pkg::ST_SETTLE:
        if (cnt_q == `RSW_SETTLE_CYC + `RSW_SYNC_LAT - 12'd1)
        begin
          cnt_d = 12'd0;
          if (!pin_s)
          begin
            state_d = rsw_pkg::ST_HOLD;
            cause_d = rsw_pkg::CAUSE_EXT;
          end
          else
          begin
            state_d = rsw_pkg::ST_FETCH;
            cause_d = pend_cm_q ? rsw_pkg::CAUSE_CMON
                                : rsw_pkg::CAUSE_WDOG;
          end
        end
      rsw_pkg::ST_FETCH:
        if (cnt_q == `RSW_FETCH_CYC - 12'd1)
        begin
          state_d = rsw_pkg::ST_RUN;
          cnt_d   = 12'd0;
        end
      rsw_pkg::ST_RUN:
      begin
        cnt_d = 12'd0;
        if (ctl.wd_fire || ctl.cm_fail || !pin_s)
        begin
          state_d   = rsw_pkg::ST_DRIVE;
          pend_cm_d = ctl.cm_fail;
        end
      end
      default:
      begin
        state_d = rsw_pkg::ST_POR;
        cnt_d   = 12'd0;
      end
    endcase
  end

  // Sequencer registers; the cause stays put until the next reset.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q   <= rsw_pkg::ST_POR;
      cause_q   <= rsw_pkg::CAUSE_EXT;
      cnt_q     <= 12'd0;
      pend_cm_q <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      cause_q   <= cause_d;
      cnt_q     <= cnt_d;
      pend_cm_q <= pend_cm_d;
    end
  end

  // -------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------
  logic        core_rst_n_q;
  logic        vec_fetch_q;
  logic [15:0] vec_addr_q;
  logic        pin_oe_q;
  logic        pin_o_q;

  // Core held in reset through the fetch window; vector from the cause.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      core_rst_n_q <= 1'b0;
      vec_fetch_q  <= 1'b0;
      vec_addr_q   <= 16'h0000;
      pin_oe_q     <= 1'b1;
      pin_o_q      <= 1'b0;
    end
    else
    begin
      core_rst_n_q <= state_d == rsw_pkg::ST_RUN;
      vec_fetch_q  <= state_d == rsw_pkg::ST_FETCH;
      vec_addr_q   <= vector(cause_d, mode_s);
      pin_oe_q     <= state_d == rsw_pkg::ST_DRIVE ||
                      state_d == rsw_pkg::ST_POR;
      pin_o_q      <= 1'b0;
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign rst_pin_o  = pin_o_q;
  assign rst_pin_oe = pin_oe_q;
  assign core_rst_n = core_rst_n_q;
  assign vec_fetch  = vec_fetch_q;
  assign vec_addr   = vec_addr_q;

endmodule // rsw_top
`default_nettype wire

// ---- tb/rsw_pin_model.sv ----
// Far side of the reset pin and the source of the monitored E clock.
// Assumes a stiff pull-up on the pin and a bench that sets the controls.
`default_nettype none
module rsw_pin_model (
  // Clock and bench controls
  input  wire logic clk,
  input  wire logic hold_low,
  input  wire logic e_stop,
  // Device side of the pin
  input  wire logic rst_pin_o,
  input  wire logic rst_pin_oe,
  output var  logic pin_level,
  output var  logic e_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_q = 2'h0;
  // A stiff pull-up lets the pin rise at once, so the cause is never misread.
  assign pin_level = ((rst_pin_oe && !rst_pin_o) || hold_low) ? 1'b0 : 1'b1;
  // E clock at a quarter of clk; stopping it freezes its level.
  always @(posedge clk)
    if (!e_stop) div_q <= div_q + 2'h1;
  assign e_clk = div_q[1];
endmodule // rsw_pin_model
`default_nettype wire

// ---- tb/rsw_top_sva.sv ----
// Checker for the reset controller, watching the top ports only.
// Assumes one clock domain and the index map of the register header.
`include "rsw_regs.svh"
`default_nettype none
module rsw_top_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // Watched ports
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rst_pin_i,
  input wire logic        rst_pin_oe,
  input wire logic        special_mode_pin,
  input wire logic        core_rst_n,
  input wire logic        vec_fetch,
  input wire logic [15:0] vec_addr
);
  logic [12:0] por_q;
  logic [5:0]  idx;
  assign idx = paddr[7:2];
  // Age since power-on release; it saturates so it can never wrap back.
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n) por_q <= 13'h0;
    else if (por_q != 13'h1fff) por_q <= por_q + 13'h1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // --------------------
  // Properties
  // --------------------
  property p_por; por_q < 13'd4060 |-> rst_pin_oe; endproperty
  property p_drive; $rose(rst_pin_oe) |-> rst_pin_oe[*4] ##1 !rst_pin_oe;
  endproperty
  // Power-on release samples the pin at once, so only later drives count.
  property p_settle;
    $fell(rst_pin_oe) && por_q > 13'd4064 |-> (!vec_fetch)[*4];
  endproperty
  property p_fetch;
    $rose(vec_fetch) |-> vec_fetch[*3] ##1 (!vec_fetch && core_rst_n);
  endproperty
  property p_page; vec_fetch |-> vec_addr[15:8] ==
    (special_mode_pin ? `RSW_VEC_SPECIAL : `RSW_VEC_NORMAL); endproperty
  property p_cause;
    vec_fetch |-> vec_addr[7:0] inside {8'hfe, 8'hfc, 8'hfa};
  endproperty
  property p_quiet; core_rst_n |-> !rst_pin_oe && !vec_fetch; endproperty
  property p_rise; $rose(core_rst_n) |-> $past(vec_fetch); endproperty
  property p_hold; !core_rst_n && !rst_pin_i |=> (!core_rst_n)[*2];
  endproperty
  property p_err; pready && !(idx inside {6'h39, 6'h3a, 6'h3b, 6'h3e,
    6'h3f}) |-> pslverr; endproperty
  a_por: assert property (p_por)
    else $error("pin freed early");
  a_drive: assert property (p_drive)
    else $error("drive not four cycles");
  a_settle: assert property (p_settle)
    else $error("fetch before sample");
  a_fetch: assert property (p_fetch)
    else $error("fetch not three cycles");
  a_page: assert property (p_page)
    else $error("wrong vector page");
  a_cause: assert property (p_cause)
    else $error("wrong vector pair");
  a_quiet: assert property (p_quiet)
    else $error("reset activity in run");
  a_rise: assert property (p_rise)
    else $error("run without fetch");
  a_hold: assert property (p_hold)
    else $error("left reset with pin low");
  a_err: assert property (p_err)
    else $error("unmapped without error");
  c_wdog: cover property (vec_fetch && vec_addr[7:0] == 8'hfa);
  c_cmon: cover property (vec_fetch && vec_addr[7:0] == 8'hfc);
  c_spec: cover property (vec_fetch && vec_addr[15:8] == 8'hbf);
endmodule // rsw_top_chk

bind rsw_top rsw_top_chk rsw_top_chk_i (.clk(clk), .reset_n(reset_n),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .rst_pin_i(rst_pin_i),
  .rst_pin_oe(rst_pin_oe), .special_mode_pin(special_mode_pin),
  .core_rst_n(core_rst_n), .vec_fetch(vec_fetch), .vec_addr(vec_addr));
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the reset controller with a register model.
// Assumes the pin model and the checker are compiled before it.
`include "rsw_regs.svh"
`default_nettype none
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin \
  bad_count++; $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        spec = 1'b0;
  logic        hold_low = 1'b0;
  logic        e_stop = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, pin_o, pin_oe, pin, e_clk;
  logic        core_rst_n, vec_fetch;
  logic [15:0] vec_addr;
  int          checked = 0;
  int          bad_count = 0;
  int          cyc = 0;
  int          falls = 0;
  logic [7:0]  m_opt, m_cfg, m_tst;
  logic [1:0]  m_cause;
  bit          m_lock, m_cdone;
  int          m_run = 0;
  // --------------------
  // Design and far side
  // --------------------
  rsw_top #(.WD_BASE_LOG2(4), .CM_TMO(20)) rsw_top_i (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rst_pin_i(pin),
    .rst_pin_o(pin_o), .rst_pin_oe(pin_oe), .special_mode_pin(spec),
    .e_clk_pin(e_clk), .core_rst_n(core_rst_n), .vec_fetch(vec_fetch),
    .vec_addr(vec_addr));
  rsw_pin_model rsw_pin_model_i (.clk(clk), .hold_low(hold_low),
    .e_stop(e_stop), .rst_pin_o(pin_o), .rst_pin_oe(pin_oe),
    .pin_level(pin), .e_clk(e_clk));
  // Clock, reset counter and a hang limit well above the roughly 9100 cycles used.
  always #25 clk = ~clk;
  always @(negedge core_rst_n) falls++;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Every reset returns the register model to its initial values.
  task automatic reset_model(input logic [1:0] c);
    m_opt = `RSW_OPT_RESET;
    m_cfg = `RSW_CFG_RESET;
    m_tst = spec ? 8'h80 : 8'h00;
    m_cause = c;
    m_lock = 0;
    m_cdone = 0;
    m_run = cyc;
  endtask
  // One APB transfer; the request holds until pready is seen at an edge.
  task automatic apb(input logic w, input logic [5:0] ix,
                     input logic [7:0] d, output logic [7:0] r,
                     output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] ix, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    apb(1'b1, ix, d, r, e);
    if (ix == `RSW_IDX_OPTIONS)
    begin
      m_opt[7:3] = d[7:3];
      m_opt[2] = m_opt[2] | d[2];
      if (spec || (!m_lock && cyc - m_run < 64))
        m_opt[1:0] = d[1:0];
      m_lock = 1;
    end
    if (ix == `RSW_IDX_CONFIG && (spec || !m_cdone)) m_cfg = d;
    if (ix == `RSW_IDX_CONFIG) m_cdone = 1;
    if (ix == `RSW_IDX_TEST && spec) m_tst = d;
  endtask
  task automatic rd(input logic [5:0] ix, input logic [7:0] mk,
                    input string nm);
    logic [7:0] r, x;
    logic e;
    apb(1'b0, ix, 8'h00, r, e);
    case (ix)
      `RSW_IDX_OPTIONS: x = m_opt;
      `RSW_IDX_CONFIG:  x = m_cfg;
      `RSW_IDX_TEST:    x = m_tst;
      default:          x = {5'h0, spec, m_cause};
    endcase
    `CHK(nm, x & mk, r & mk)
  endtask
  // Software service: arm, something else in between, then clear.
  task automatic svc();
    wr(`RSW_IDX_SERVICE, `RSW_SVC_ARM);
    rd(`RSW_IDX_OPTIONS, 8'hff, "opt_svc");
    wr(`RSW_IDX_SERVICE, `RSW_SVC_CLEAR);
  endtask
  // Waits for a reset and its restart, checking timing, drive and vector.
  task automatic wait_run(input logic [15:0] ev, input int ed, lo, hi,
                          input logic [1:0] c);
    int n, d;
    logic [15:0] va;
    n = 0;
    va = 16'h0;
    while (core_rst_n !== 1'b0 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    `CHK("fall", 1'b1, n >= lo && n <= hi)
    d = (pin_oe === 1'b1) ? 1 : 0;
    n = 0;
    while (core_rst_n !== 1'b1 && n < 6000)
    begin
      @(posedge clk);
      n++;
      if (pin_oe === 1'b1) d++;
      if (pin_oe === 1'b1) `CHK("pin_o", 1'b0, pin_o)
      if (vec_fetch === 1'b1) va = vec_addr;
    end
    if (ed > 0) `CHK("drive", ed, d)
    `CHK("vector", ev, va)
    reset_model(c);
  endtask
  initial
  begin
    logic [7:0] r;
    logic e;
    logic [3:0] nib;
    int f0;
    void'($urandom(32'h2a4e));
    nib = 4'($urandom_range(15, 0));
    reset_model(2'h0);
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    wait_run(16'hfffe, 0, 0, 0, 2'h0);
    rd(`RSW_IDX_OPTIONS, 8'hff, "opt_rst");
    wr(`RSW_IDX_OPTIONS, {nib, 4'h1});
    svc();
    wr(`RSW_IDX_OPTIONS, {nib, 4'h3});
    rd(`RSW_IDX_OPTIONS, 8'hff, "opt_once");
    svc();
    rd(`RSW_IDX_STATUS, 8'h07, "cause_por");
    apb(1'b0, 6'h00, 8'h00, r, e);
    `CHK("slverr", 1'b1, e)
    rd(`RSW_IDX_CONFIG, 8'h04, "cfg_rst");
    repeat (3)
    begin
      svc();
      repeat ($urandom_range(8, 0)) @(posedge clk);
    end
    wait_run(16'hfffa, 4, 56, 72, 2'h2);
    wr(`RSW_IDX_CONFIG, 8'h04);
    rd(`RSW_IDX_STATUS, 8'h07, "cause_wdog");
    rd(`RSW_IDX_OPTIONS, 8'hff, "opt_again");
    f0 = falls;
    repeat (300) @(posedge clk);
    `CHK("no_wdog", f0, falls)
    wr(`RSW_IDX_CONFIG, 8'h00);
    rd(`RSW_IDX_CONFIG, 8'h04, "cfg_once");
    $display("test watchdog done");
    wr(`RSW_IDX_OPTIONS, 8'h0d);
    wr(`RSW_IDX_OPTIONS, 8'h00);
    rd(`RSW_IDX_OPTIONS, 8'hff, "force");
    e_stop <= 1'b1;
    wait_run(16'hfffc, 4, 15, 40, 2'h1);
    e_stop <= 1'b0;
    rd(`RSW_IDX_STATUS, 8'h07, "cause_cmon");
    hold_low <= 1'b1;
    fork
      begin
        repeat (30) @(posedge clk);
        hold_low <= 1'b0;
      end
    join_none
    wait_run(16'hfffe, 4, 1, 10, 2'h0);
    $display("test sources done");
    spec <= 1'b1;
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    wait_run(16'hbffe, 0, 0, 0, 2'h0);
    rd(`RSW_IDX_TEST, 8'h80, "inhibit");
    f0 = falls;
    repeat (100) @(posedge clk);
    `CHK("inhibited", f0, falls)
    wr(`RSW_IDX_CONFIG, 8'h04);
    wr(`RSW_IDX_CONFIG, 8'h00);
    rd(`RSW_IDX_CONFIG, 8'h04, "cfg_spec");
    wr(`RSW_IDX_OPTIONS, 8'h02);
    rd(`RSW_IDX_OPTIONS, 8'hff, "opt_spec");
    wr(`RSW_IDX_TEST, 8'h00);
    wait_run(16'hbffa, 4, 250, 262, 2'h2);
    rd(`RSW_IDX_STATUS, 8'h07, "cause_spec");
    $display("test special done");
    give_verdict();
  end
endmodule // tb
`default_nettype wire
